// file: rtl/ppm_pkg.sv
// Package for the shared address/data pin multiplexer.
// Assumes a single core clock domain; one software-visible register, system control.
package ppm_pkg;
   localparam int          PPM_PIN_W         = 16;
   localparam int          PPM_ADDR_W        = 24;
   localparam int          PPM_BYTE_W        = 8;
   localparam int          PPM_FLAG_SEL_BIT  = 20;    // Flag-select bit of system_control_register
   localparam int          PPM_SYS_CTRL_W    = 32;
   localparam logic [31:0] PPM_SYS_CTRL_RST  = 32'h0000_0000;
   localparam logic [15:0] PPM_PINS_RST      = 16'h0000;
   localparam logic        PPM_STROBE_IDLE_B = 1'b1;  // Read/write strobes idle high
   localparam logic        PPM_ALE_IDLE      = 1'b0;

   // Port data width selection
   typedef enum logic {
      PPM_WIDTH_8,
      PPM_WIDTH_16
   } ppm_width_t;

   // Bus phase of the parallel port
   typedef enum logic [1:0] {
      PPM_PH_IDLE,
      PPM_PH_ADDR,
      PPM_PH_DATA
   } ppm_phase_t;
endpackage : ppm_pkg

// file: rtl/ppm_flag_if.sv
// Interface carrying flag-mode pin values between the mux top and the flag remapper.
// Assumes both ends share clk_sys.
`timescale 1ns/10ps
interface ppm_flag_if;
   logic [15:0] flag_out;    // Flag values in flag numbering
   logic [15:0] flag_oe;
   logic [15:0] pin_out;     // Same values in pin numbering
   logic [15:0] pin_oe;
   logic [15:0] pin_in;
   logic [15:0] flag_in;
   modport top (output flag_out, output flag_oe, output pin_in, input pin_out, input pin_oe, input flag_in);
   modport remap (input flag_out, input flag_oe, input pin_in, output pin_out, output pin_oe, output flag_in);
endinterface : ppm_flag_if

// file: rtl/ppm_flag_remap.sv
// Fixed swap between pin numbering and flag numbering.
// Assumes purely combinational use inside the mux top.
`timescale 1ns/10ps
module ppm_flag_remap (
   ppm_flag_if.remap fi
);
   import ppm_pkg::*;

   // Swap bytes: pins 7..0 are flags 15..8, pins 15..8 are flags 7..0
   function automatic logic [15:0] swap_bytes(input logic [15:0] v);
      swap_bytes = {v[7:0], v[15:8]};
   endfunction : swap_bytes

   assign fi.pin_out = swap_bytes(fi.flag_out);
   assign fi.pin_oe  = swap_bytes(fi.flag_oe);
   assign fi.flag_in = swap_bytes(fi.pin_in);
endmodule : ppm_flag_remap

// file: rtl/ppm_pin_mux.sv
// Multiplexer for the sixteen shared address/data pins: port address/data phases or flags.
// Assumes the port engine presents address, data and phase synchronous to clk_sys.
// Outputs are registered, so every pin change lands one clock after its request.
//
// What this block does
// - Setting flag-select bit 20 of system control turns pins into flags.
// - Pins 0..7 are flags 8..15; pins 8..15 are flags 0..7.
// - 8-bit mode, latch asserted: low byte A15..8, high byte A23..16.
// - 8-bit mode, latch deasserted: low byte D7..0, high byte A7..0.
// - 16-bit mode, latch asserted: low byte A7..0, high byte A15..8.
// - 16-bit mode, latch deasserted: low byte D7..0, high byte D15..8.
// - Read, write and latch strobes are always driven, never floated.
`timescale 1ns/10ps
module ppm_pin_mux (
   input  wire logic                       clk_sys,
   input  wire logic                       rst_b,
   // System control register write port from the core
   input  wire logic                       sys_ctrl_wr,
   input  wire logic [31:0]                sys_ctrl_wdata,
   output logic [31:0]                     system_control_register,
   // Parallel port engine side
   input  wire ppm_pkg::ppm_width_t        ext_port_width,
   input  wire ppm_pkg::ppm_phase_t        port_phase,
   input  wire logic                       port_write,
   input  wire logic [23:0]                port_addr,
   input  wire logic [15:0]                port_wdata,
   output logic [15:0]                     port_rdata,
   output logic                            flag_mode,
   // General flags seen by the core
   input  wire logic [15:0]                flag_out,
   input  wire logic [15:0]                flag_oe,
   output logic [15:0]                     general_flag_pins,
   // Pins
   input  wire logic [15:0]                addr_data_pins_in,
   output logic [15:0]                     addr_data_pins_out,
   output logic [15:0]                     addr_data_pins_oe,
   output logic                            ale,
   output logic                            rd_b,
   output logic                            wr_b
);
   import ppm_pkg::*;

   ppm_flag_if fi ();

   logic [31:0] sys_ctrl_reg;
   logic        flag_sel;
   logic        addr_cycle;
   logic        data_cycle;
   logic        read_cycle;
   logic        write_cycle;
   logic [15:0] pin_next;
   logic [15:0] oe_next;
   logic [15:0] pins_out_reg;
   logic [15:0] pins_oe_reg;
   logic [15:0] rdata_reg;
   logic [15:0] flags_in_reg;
   logic        ale_reg;
   logic        rd_b_reg;
   logic        wr_b_reg;

   // One decode feeds the strobes and the read capture, so the two can never disagree
   function automatic logic in_phase(input logic flags_on, input ppm_phase_t ph, input ppm_phase_t want);
      in_phase = !flags_on && (ph == want);
   endfunction : in_phase

   ////////////////////////////////////////////////////////////////////////////////
   // Flag remapping

   // The swap lives in its own module so the mapping is written in one place only
   ppm_flag_remap u_remap (
      .fi (fi.remap)
   );

   assign fi.flag_out = flag_out;
   assign fi.flag_oe  = flag_oe;
   assign fi.pin_in   = addr_data_pins_in;

   ////////////////////////////////////////////////////////////////////////////////
   // System control register

   // Whole word stored; only the flag-select bit steers this block
   // Other bits are kept so software reads back what it wrote
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sys_ctrl_reg <= PPM_SYS_CTRL_RST;
      end else if (sys_ctrl_wr) begin
         sys_ctrl_reg <= sys_ctrl_wdata;
      end
   end

   assign flag_sel = sys_ctrl_reg[PPM_FLAG_SEL_BIT];

   ////////////////////////////////////////////////////////////////////////////////
   // Port cycle decode

   // Flag mode masks every port cycle; a port left running cannot reach the pins
   assign addr_cycle  = in_phase(flag_sel, port_phase, PPM_PH_ADDR);
   assign data_cycle  = in_phase(flag_sel, port_phase, PPM_PH_DATA);
   assign read_cycle  = data_cycle && !port_write;
   assign write_cycle = data_cycle && port_write;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin value selection

   // Flag mode overrides the port; software is expected to idle the port first
   always_comb begin
      pin_next = PPM_PINS_RST;
      oe_next  = PPM_PINS_RST;
      if (flag_sel) begin
         pin_next = fi.pin_out;
         oe_next  = fi.pin_oe;
      end else begin
         case (port_phase)
            PPM_PH_ADDR: begin
               // Address phase drives every pin; the external latch takes all sixteen bits
               oe_next = 16'hFFFF;
               if (ext_port_width == PPM_WIDTH_8) begin
                  pin_next = port_addr[23:8];
               end else begin
                  pin_next = port_addr[15:0];
               end
            end
            PPM_PH_DATA: begin
               if (ext_port_width == PPM_WIDTH_8) begin
                  // High byte keeps carrying the low address byte during reads too
                  pin_next = {port_addr[7:0], port_wdata[7:0]};
                  oe_next  = {8'hFF, {8{port_write}}};
               end else begin
                  pin_next = port_wdata;
                  oe_next  = {16{port_write}};
               end
            end
            // Idle releases the pins so the pull-ups hold them between cycles
            PPM_PH_IDLE: begin
               pin_next = PPM_PINS_RST;
               oe_next  = PPM_PINS_RST;
            end
            default: begin
               pin_next = PPM_PINS_RST;
               oe_next  = PPM_PINS_RST;
            end
         endcase
      end
   end

   // Pin drivers registered so outputs come straight from flops
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pins_out_reg <= PPM_PINS_RST;
         pins_oe_reg  <= PPM_PINS_RST;
      end else begin
         pins_out_reg <= pin_next;
         pins_oe_reg  <= oe_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Strobes: always driven, idle when not in a port phase
   // None has an enable: latch and memory see a defined level even in flag mode

   // Latch strobe high for exactly the address phase
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ale_reg <= PPM_ALE_IDLE;
      end else begin
         ale_reg <= addr_cycle;
      end
   end

   // Read strobe low only while the far side may drive the pins
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rd_b_reg <= PPM_STROBE_IDLE_B;
      end else begin
         rd_b_reg <= !read_cycle;
      end
   end

   // Write strobe low while our write data stands on the pins
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wr_b_reg <= PPM_STROBE_IDLE_B;
      end else begin
         wr_b_reg <= !write_cycle;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read capture and flag inputs

   // In 8-bit mode only the low byte carries data; upper byte reads zero
   // Pins are taken at the edge that launches the read strobe: a read phase needs two cycles
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rdata_reg <= PPM_PINS_RST;
      end else if (read_cycle) begin
         if (ext_port_width == PPM_WIDTH_8) begin
            rdata_reg <= {8'h00, addr_data_pins_in[7:0]};
         end else begin
            rdata_reg <= addr_data_pins_in;
         end
      end
   end

   // Flag inputs are sampled every cycle, port mode too, so the core always sees the pins
   // The register costs one cycle of delay but keeps the output straight from a flop
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         flags_in_reg <= PPM_PINS_RST;
      end else begin
         flags_in_reg <= fi.flag_in;
      end
   end

   assign system_control_register = sys_ctrl_reg;
   assign flag_mode               = flag_sel;
   assign addr_data_pins_out      = pins_out_reg;
   assign addr_data_pins_oe       = pins_oe_reg;
   assign port_rdata              = rdata_reg;
   assign general_flag_pins       = flags_in_reg;
   assign ale                     = ale_reg;
   assign rd_b                    = rd_b_reg;
   assign wr_b                    = wr_b_reg;
endmodule : ppm_pin_mux

// file: verification/ppm_pin_mux_chk.sv
// Concurrent checks on the shared address/data pin multiplexer.
// Assumes binding onto ppm_pin_mux; one clock domain, reset active low.
`timescale 1ns/10ps
module ppm_pin_mux_chk
   import ppm_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        rst_b,
   input wire logic        sys_ctrl_wr,
   input wire logic [31:0] sys_ctrl_wdata,
   input wire ppm_width_t  ext_port_width,
   input wire ppm_phase_t  port_phase,
   input wire logic        port_write,
   input wire logic [23:0] port_addr,
   input wire logic [15:0] port_wdata,
   input wire logic [15:0] flag_out,
   input wire logic [15:0] flag_oe,
   input wire logic [15:0] addr_data_pins_in,
   input wire logic        flag_mode,
   input wire logic [15:0] general_flag_pins,
   input wire logic [15:0] addr_data_pins_out,
   input wire logic [15:0] addr_data_pins_oe,
   input wire logic        ale,
   input wire logic        rd_b,
   input wire logic        wr_b
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////////////
   // Port cycles only count while flag mode is off
   wire port_on = !flag_mode;
   wire is8 = ext_port_width == PPM_WIDTH_8;
   wire ph_a = port_on && port_phase == PPM_PH_ADDR;
   wire ph_d = port_on && port_phase == PPM_PH_DATA;
   flag_sel_a: assert property (sys_ctrl_wr |=> flag_mode == $past(sys_ctrl_wdata[PPM_FLAG_SEL_BIT]))
      else $error("flag mode does not follow select bit");
   flag_hush_a: assert property (flag_mode |=> !ale && rd_b && wr_b)
      else $error("strobe active in flag mode");
   flag_out_a: assert property (flag_mode |=>
      addr_data_pins_out == {$past(flag_out[7:0]), $past(flag_out[15:8])}
      && addr_data_pins_oe == {$past(flag_oe[7:0]), $past(flag_oe[15:8])})
      else $error("flag drive not remapped");
   flag_in_a: assert property (flag_mode |=>
      general_flag_pins == {$past(addr_data_pins_in[7:0]), $past(addr_data_pins_in[15:8])})
      else $error("flag input not remapped");
   addr8_a: assert property (ph_a && is8 |=>
      ale && addr_data_pins_out == $past(port_addr[23:8]) && addr_data_pins_oe == 16'hFFFF)
      else $error("narrow address phase wrong");
   // Write or read is the one of the cycle that launched the data phase
   data8_a: assert property (ph_d && is8 |=>
      !ale && addr_data_pins_out[15:8] == $past(port_addr[7:0])
      && addr_data_pins_oe == {8'hFF, {8{$past(port_write)}}}
      && ($past(port_write) ? addr_data_pins_out[7:0] == $past(port_wdata[7:0]) && !wr_b : !rd_b))
      else $error("narrow data phase wrong");
   addr16_a: assert property (ph_a && !is8 |=> ale && addr_data_pins_out == $past(port_addr[15:0]))
      else $error("wide address phase wrong");
   data16_a: assert property (ph_d && !is8 && port_write |=>
      !ale && !wr_b && addr_data_pins_out == $past(port_wdata) && addr_data_pins_oe == 16'hFFFF)
      else $error("wide data phase wrong");
   read16_a: assert property (ph_d && !is8 && !port_write |=>
      !ale && !rd_b && wr_b && addr_data_pins_oe == 16'h0000)
      else $error("wide read phase wrong");
   idle_rel_a: assert property (port_on && port_phase == PPM_PH_IDLE |=>
      !ale && rd_b && wr_b && addr_data_pins_oe == 16'h0000)
      else $error("idle phase drives pins");
   strobe_excl_a: assert property (!(ale && (!rd_b || !wr_b)) && (rd_b || wr_b))
      else $error("strobes overlap");
endmodule : ppm_pin_mux_chk
bind ppm_pin_mux ppm_pin_mux_chk chk_u (.clk_sys, .rst_b, .sys_ctrl_wr, .sys_ctrl_wdata, .ext_port_width,
   .port_phase, .port_write, .port_addr, .port_wdata, .flag_out, .flag_oe, .addr_data_pins_in, .flag_mode,
   .general_flag_pins,
   .addr_data_pins_out, .addr_data_pins_oe, .ale, .rd_b, .wr_b);

// file: verification/ppm_ext_mem.sv
// External address latch and memory facing the shared pins.
// Assumes pull-ups on every pin; the memory answers only while read is low.
`timescale 1ns/10ps
module ppm_ext_mem (
   input  wire logic        clk_sys,
   input  wire logic        ale,
   input  wire logic        rd_b,
   input  wire logic        wr_b,
   input  wire logic [15:0] pin_o,
   input  wire logic [15:0] pin_oe,
   output logic      [15:0] pins,
   output logic      [15:0] wseen
);
   logic [15:0] latch_q = 16'h0000;
   // Latch takes the pins at the edge that closes the strobe high time
   always @(posedge clk_sys) if (ale) latch_q <= pins;
   // Write data taken while the write strobe is low
   always @(posedge clk_sys) if (!wr_b) wseen <= pins;
   // Read answer is inverted address so a stale bus cannot pass as data
   assign pins = (pin_oe & pin_o) | (~pin_oe & (!rd_b ? ~latch_q : 16'hFFFF));
endmodule : ppm_ext_mem

// file: verification/tb_top.sv
// Self-checking bench for the shared address/data pin multiplexer.
// Assumes ppm_ext_mem on the pins and the checker bound to the design.
`timescale 1ns/10ps
module tb_top;
   import ppm_pkg::*;
   logic        clk_sys = 1'b0, rst_b = 1'b0, sys_ctrl_wr = 1'b0, port_write = 1'b0, ale, rd_b, wr_b, flag_mode;
   logic [31:0] sys_ctrl_wdata = 32'h0, sys_q;
   ppm_width_t  ext_port_width = PPM_WIDTH_16;
   ppm_phase_t  port_phase = PPM_PH_IDLE;
   logic [23:0] port_addr = 24'h0;
   logic [15:0] port_wdata = 16'h0, flag_out = 16'h0, flag_oe = 16'h0, rdata, gfp, pin_o, pin_oe, pins, wseen;
   int          error_cnt = 0, total_checks = 0, cyc = 0;
   always #5 clk_sys = ~clk_sys;
   ppm_pin_mux dut_u (.clk_sys, .rst_b, .sys_ctrl_wr, .sys_ctrl_wdata, .system_control_register(sys_q),
      .ext_port_width, .port_phase, .port_write, .port_addr, .port_wdata, .port_rdata(rdata), .flag_mode,
      .flag_out, .flag_oe, .general_flag_pins(gfp), .addr_data_pins_in(pins), .addr_data_pins_out(pin_o),
      .addr_data_pins_oe(pin_oe), .ale, .rd_b, .wr_b);
   ppm_ext_mem mem_u (.clk_sys, .ale, .rd_b, .wr_b, .pin_o, .pin_oe, .pins, .wseen);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic stop_test();
      if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : stop_test
   // Address, write, then a two-cycle read so the second capture sees the memory
   task automatic port_seq(ppm_width_t w, logic [23:0] a, logic [15:0] d, ea, ed, er);
      @(negedge clk_sys);
      ext_port_width = w;
      port_addr = a;
      port_wdata = d;
      port_phase = PPM_PH_ADDR;
      @(negedge clk_sys);
      chk("addr pins", pin_o, ea);
      port_phase = PPM_PH_DATA;
      port_write = 1'b1;
      @(negedge clk_sys);
      chk("write pins", pin_o, ed);
      port_write = 1'b0;
      repeat (2) @(negedge clk_sys);
      port_phase = PPM_PH_IDLE;
      @(negedge clk_sys);
      chk("read data", rdata, er);
      chk("latched write", wseen, ed);
   endtask : port_seq
   task automatic t_port16();
      port_seq(PPM_WIDTH_16, 24'h5AC3E1, 16'h1234, 16'hC3E1, 16'h1234, 16'h3C1E);
   endtask : t_port16
   task automatic t_port8();
      port_seq(PPM_WIDTH_8, 24'h5AC3E1, 16'h0077, 16'h5AC3, 16'hE177, 16'h003C);
   endtask : t_port8
   // Flag mode with a port address request left pending, which must be ignored
   task automatic t_flags();
      @(negedge clk_sys);
      {sys_ctrl_wr, sys_ctrl_wdata, flag_out, flag_oe} = {1'b1, 32'h0010_0000, 16'h12F0, 16'h00FF};
      port_phase = PPM_PH_IDLE;
      @(negedge clk_sys);
      sys_ctrl_wr = 1'b0;
      port_phase = PPM_PH_ADDR;
      @(negedge clk_sys);
      chk("flag mode", {sys_q[31:1], flag_mode}, 32'h0010_0001);
      chk("flag drive", {pin_o, pin_oe}, 32'hF012_FF00);
      chk("strobes", {ale, rd_b, wr_b}, 32'h3);
      @(negedge clk_sys);
      chk("flag input", gfp, 16'hFFF0);
      sys_ctrl_wr = 1'b1;
      sys_ctrl_wdata = 32'h0;
      port_phase = PPM_PH_IDLE;
      @(negedge clk_sys);
      sys_ctrl_wr = 1'b0;
      @(negedge clk_sys);
      chk("flag off", flag_mode, 32'h0);
   endtask : t_flags
   // Reset in mid-run with a flag select and an address phase just taken must return every output to its reset value
   task automatic t_reset();
      @(negedge clk_sys);
      sys_ctrl_wr = 1'b1;
      sys_ctrl_wdata = 32'h0010_0000;
      port_phase = PPM_PH_ADDR;
      @(negedge clk_sys);
      sys_ctrl_wr = 1'b0;
      rst_b = 1'b0;
      @(negedge clk_sys);
      chk("reset control", {sys_q[31:1], flag_mode}, 32'h0);
      chk("reset drive", {pin_o, pin_oe}, 32'h0);
      chk("reset strobes", {ale, rd_b, wr_b}, 32'h3);
      chk("reset read data", rdata, 32'h0);
      chk("reset flag input", gfp, 32'h0);
      port_phase = PPM_PH_IDLE;
      rst_b = 1'b1;
   endtask : t_reset
   // Cycle ceiling well above the few dozen cycles the run needs
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc > 1000) begin
         error_cnt++;
         stop_test();
      end
   end
   initial begin
      repeat (5) @(negedge clk_sys);
      rst_b = 1'b1;
      t_port16();
      t_port8();
      t_reset();
      t_flags();
      stop_test();
   end
endmodule : tb_top
